// >>> design/pzd_params.svh
/*
 * constants for the piezo drive setpoint control block: register offsets,
 * field positions, reset values, voltage codes and timing figures.
 * assumes a drive code of 10 mV per step and a 100 MHz system clock.
 */
`ifndef PZD_PARAMS_SVH
`define PZD_PARAMS_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define PZD_OFS_CONFIG   8'h00
`define PZD_OFS_STEP     8'h04
`define PZD_OFS_SETPOINT 8'h08
`define PZD_OFS_TEACH1   8'h0C
`define PZD_OFS_TEACH2   8'h10
`define PZD_OFS_STATUS   8'h14

// ****************************************************************
// config field positions
// ****************************************************************
`define PZD_CFG_HV      0
`define PZD_CFG_RANGE   1
`define PZD_CFG_LOOP    3
`define PZD_CFG_SRC     4
`define PZD_CFG_WMODE   6
`define PZD_CFG_SPEED   8

// ****************************************************************
// voltage codes, 10 mV per step
// ****************************************************************
`define PZD_VMAX_75     16'h1D4C
`define PZD_VMAX_100    16'h2710
`define PZD_VMAX_150    16'h3A98
`define PZD_SPEED_HIGH  16'h0064
`define PZD_SPEED_MED   16'h000A
`define PZD_SPEED_LOW   16'h0001
`define PZD_STEP_RESET  16'h000A
`define PZD_TEACH_RESET 16'h0000

// ****************************************************************
// timing
// ****************************************************************
`define PZD_CLK_PERIOD_NS 10
`define PZD_RAMP_STEP_US  10
`define PZD_RAMP_CYCLES   ((`PZD_RAMP_STEP_US * 1000) / `PZD_CLK_PERIOD_NS)

`endif

// >>> design/pzd_pkg.sv
/*
 * types of the piezo drive setpoint control block.
 * assumes nothing of its surroundings.
 */
package pzd_pkg;

  typedef enum logic [1:0] {PZD_R75, PZD_R100, PZD_R150} pzd_range_t;
  typedef enum logic {PZD_OPEN, PZD_CLOSED} pzd_loop_t;
  typedef enum logic [1:0] {PZD_SRC_COAX, PZD_SRC_HUB1, PZD_SRC_HUB2,
                            PZD_SRC_OFF} pzd_src_t;
  typedef enum logic [1:0] {PZD_WM_ADJUST, PZD_WM_JOG,
                            PZD_WM_PRESET} pzd_wmode_t;
  typedef enum logic [1:0] {PZD_SP_HIGH, PZD_SP_MED, PZD_SP_LOW} pzd_speed_t;
  typedef enum logic [1:0] {PZD_MS_MAIN, PZD_MS_LIST, PZD_MS_EDIT} pzd_menu_t;
  typedef enum logic [2:0] {PZD_MI_HV, PZD_MI_RANGE, PZD_MI_LOOP, PZD_MI_SRC,
                            PZD_MI_WMODE, PZD_MI_WPARAM,
                            PZD_MI_TEACH} pzd_item_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pzd_bus_req_t;

  typedef struct packed {
    logic        route_en;
    pzd_src_t    route_sel;
    logic        drive_from_input;
    logic        feedback_from_input;
    logic        modulation_accept;
  } pzd_route_t;

  typedef struct packed {
    logic [7:0]  src_char;
    logic [7:0]  mode_char;
    logic        show_percent;
    pzd_menu_t   menu;
    pzd_item_t   item;
  } pzd_disp_t;

  typedef struct packed {
    logic [3:0]  s2;
    logic [3:0]  s3;
    logic [3:0]  s1;
    logic [3:0]  filt;
    logic        hv_en;
    pzd_range_t  range;
    pzd_loop_t   loop;
    pzd_src_t    src;
    pzd_wmode_t  wmode;
    pzd_speed_t  speed;
    logic [15:0] step;
    logic [15:0] drive;
    logic [15:0] teach1;
    logic [15:0] teach2;
    pzd_menu_t   menu;
    pzd_item_t   item;
    logic [15:0] edit_val;
    logic [15:0] ramp_cnt;
    logic        ramping;
    pzd_route_t  route;
    pzd_disp_t   disp;
    logic [31:0] rdata;
  } pzd_state_t;

endpackage : pzd_pkg

// >>> design/pzd_setpoint_ctrl.sv
/*
 * piezo drive setpoint and mode control: wheel and menu button handling,
 * range, loop mode, input routing, display indicators and register port.
 * assumes wheel click, menu button and feedback-present pins are
 * asynchronous levels; register master is on clk_sys.
 */
// Operation
// - range setting holds 75 V, 100 V or 150 V maximum
// - loop mode always starts open after reset
// - closed loop, no feedback: ramp to limit; 100 V range ramps to 150
// - closed loop shows position as percent of travel
// - input select: coax, hub one, hub two, off; off disables path
// - open loop input drives amplifier; closed loop input is feedback
// - closed loop keeps the input selection but routes coax for off, input always present
// - source character S, 1, 2 or N on lower display line
// - closed loop refuses modulation of the drive output
// - jog mode moves one configured step per wheel click
// - adjust mode moves 1 V, 100 mV or 10 mV per detent by speed
// - preset mode jumps to one of two teach voltages by direction
// - wheel mode character A, J or G at right of bottom line
// - jog step edited by menu press then wheel turns
// - wheel cycles values, menu press commits and returns to main
// - output starts disabled; other settings refused until enabled
`timescale 1ns/1ps
`include "pzd_params.svh"

module pzd_setpoint_ctrl #(
  parameter int RAMP_CYCLES = `PZD_RAMP_CYCLES
) (
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire logic               wheel_up_pin,
  input  wire logic               wheel_down_pin,
  input  wire logic               menu_btn_pin,
  input  wire logic               feedback_present_pin,
  input  wire pzd_pkg::pzd_bus_req_t bus_req,
  output logic [31:0]             bus_rdata,
  output logic [15:0]             drive_code,
  output logic                    high_voltage_output_enable,
  output pzd_pkg::pzd_route_t     route,
  output pzd_pkg::pzd_disp_t      disp
);
  import pzd_pkg::*;

  pzd_state_t st;
  pzd_state_t next_st;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [15:0] range_max(input pzd_range_t r);
    unique case (r)
      PZD_R75:  range_max = `PZD_VMAX_75;
      PZD_R100: range_max = `PZD_VMAX_100;
      default:  range_max = `PZD_VMAX_150;
    endcase
  endfunction : range_max

  // clamp a signed request into 0..range maximum
  function automatic logic [15:0] clamp(input logic signed [17:0] v,
                                        input pzd_range_t r);
    logic [15:0] mx;
    mx = range_max(r);
    if (v < 18'sd0) begin
      clamp = 16'h0000;
    end else if (v > $signed({2'b00, mx})) begin
      clamp = mx;
    end else begin
      clamp = v[15:0];
    end
  endfunction : clamp

  // wrap a small index up or down within n values
  function automatic logic [15:0] cyc(input logic [15:0] v,
                                      input logic [15:0] n,
                                      input logic up);
    if (up) begin
      cyc = (v + 16'h0001 >= n) ? 16'h0000 : v + 16'h0001;
    end else begin
      cyc = (v == 16'h0000) ? n - 16'h0001 : v - 16'h0001;
    end
  endfunction : cyc

  function automatic logic [15:0] speed_amount(input pzd_speed_t s);
    unique case (s)
      PZD_SP_HIGH: speed_amount = `PZD_SPEED_HIGH;
      PZD_SP_MED:  speed_amount = `PZD_SPEED_MED;
      default:     speed_amount = `PZD_SPEED_LOW;
    endcase
  endfunction : speed_amount

  // ****************************************************************
  // next state
  // ****************************************************************
  logic [3:0]  stable;
  logic [3:0]  new_filt;
  logic [3:0]  rise;
  logic        up_ev;
  logic        dn_ev;
  logic        menu_ev;
  logic        fb_present;
  logic        wheel_ev;
  logic [15:0] amount;
  logic [15:0] ramp_lim;
  logic [15:0] scroll;
  logic signed [17:0] req;

  always_comb begin
    next_st = st;
    next_st.s1 = {feedback_present_pin, menu_btn_pin, wheel_down_pin,
                  wheel_up_pin};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    stable     = ~(st.s2 ^ st.s3);
    new_filt   = (stable & st.s3) | (~stable & st.filt);
    next_st.filt = new_filt;
    rise       = new_filt & ~st.filt;
    up_ev      = rise[0];
    dn_ev      = rise[1];
    menu_ev    = rise[2];
    fb_present = new_filt[3];
    wheel_ev   = up_ev ^ dn_ev;
    amount     = 16'h0000;
    req        = 18'sd0;
    scroll     = cyc({13'h0000, st.item}, 16'h0007, up_ev);

    // ---------------- menu and wheel ----------------
    unique case (st.menu)
      PZD_MS_MAIN: begin
        if (menu_ev) begin
          next_st.menu = PZD_MS_LIST;
          next_st.item = PZD_MI_HV;
        end else if (wheel_ev && st.hv_en) begin
          unique case (st.wmode)
            PZD_WM_JOG:    amount = st.step;
            PZD_WM_ADJUST: amount = speed_amount(st.speed);
            default:       amount = 16'h0000;
          endcase
          if (st.wmode == PZD_WM_PRESET) begin
            next_st.drive = clamp($signed({2'b00, up_ev ? st.teach2
                                                     : st.teach1}),
                                  st.range);
          end else begin
            req = up_ev ? $signed({2'b00, st.drive}) + $signed({2'b00, amount})
                        : $signed({2'b00, st.drive}) - $signed({2'b00, amount});
            next_st.drive = clamp(req, st.range);
          end
        end
      end
      PZD_MS_LIST: begin
        if (menu_ev) begin
          next_st.menu = PZD_MS_EDIT;
          unique case (st.item)
            PZD_MI_HV:     next_st.edit_val = {15'h0000, st.hv_en};
            PZD_MI_RANGE:  next_st.edit_val = {14'h0000, st.range};
            PZD_MI_LOOP:   next_st.edit_val = {15'h0000, st.loop};
            PZD_MI_SRC:    next_st.edit_val = {14'h0000, st.src};
            PZD_MI_WMODE:  next_st.edit_val = {14'h0000, st.wmode};
            PZD_MI_WPARAM: next_st.edit_val = (st.wmode == PZD_WM_JOG)
                                              ? st.step
                                              : {14'h0000, st.speed};
            default:       next_st.edit_val = 16'h0000;
          endcase
        end else if (wheel_ev && st.hv_en) begin
          next_st.item = pzd_item_t'(scroll[2:0]);
        end
      end
      default: begin
        if (wheel_ev) begin
          unique case (st.item)
            PZD_MI_HV, PZD_MI_LOOP, PZD_MI_TEACH:
              next_st.edit_val = cyc(st.edit_val, 16'h0002, up_ev);
            PZD_MI_RANGE, PZD_MI_WMODE:
              next_st.edit_val = cyc(st.edit_val, 16'h0003, up_ev);
            PZD_MI_SRC:
              next_st.edit_val = cyc(st.edit_val, 16'h0004, up_ev);
            default: begin
              if (st.wmode == PZD_WM_JOG) begin
                req = up_ev ? $signed({2'b00, st.edit_val}) + 18'sd1
                            : $signed({2'b00, st.edit_val}) - 18'sd1;
                next_st.edit_val = (req < 18'sd1) ? 16'h0001
                                                  : clamp(req, st.range);
              end else begin
                next_st.edit_val = cyc(st.edit_val, 16'h0003, up_ev);
              end
            end
          endcase
        end else if (menu_ev) begin
          next_st.menu = PZD_MS_MAIN;
          unique case (st.item)
            PZD_MI_HV:    next_st.hv_en = st.edit_val[0];
            PZD_MI_RANGE: begin
              next_st.range = pzd_range_t'(st.edit_val[1:0]);
              next_st.drive = clamp($signed({2'b00, st.drive}),
                                    pzd_range_t'(st.edit_val[1:0]));
            end
            PZD_MI_LOOP:  next_st.loop  = pzd_loop_t'(st.edit_val[0]);
            PZD_MI_SRC:   next_st.src   = pzd_src_t'(st.edit_val[1:0]);
            PZD_MI_WMODE: next_st.wmode = pzd_wmode_t'(st.edit_val[1:0]);
            PZD_MI_WPARAM: begin
              if (st.wmode == PZD_WM_JOG) begin
                next_st.step = st.edit_val;
              end else begin
                next_st.speed = pzd_speed_t'(st.edit_val[1:0]);
              end
            end
            default: begin
              if (st.edit_val[0]) begin
                next_st.teach2 = st.drive;
              end else begin
                next_st.teach1 = st.drive;
              end
            end
          endcase
        end
      end
    endcase

    // ---------------- register writes ----------------
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        `PZD_OFS_CONFIG: begin
          next_st.hv_en = bus_req.wdata[`PZD_CFG_HV];
          if (st.hv_en) begin
            if (bus_req.wdata[`PZD_CFG_RANGE+1 -: 2] != 2'b11) begin
              next_st.range =
                pzd_range_t'(bus_req.wdata[`PZD_CFG_RANGE+1 -: 2]);
              next_st.drive = clamp($signed({2'b00, next_st.drive}),
                                    next_st.range);
            end
            next_st.loop  = pzd_loop_t'(bus_req.wdata[`PZD_CFG_LOOP]);
            next_st.src   = pzd_src_t'(bus_req.wdata[`PZD_CFG_SRC+1 -: 2]);
            if (bus_req.wdata[`PZD_CFG_WMODE+1 -: 2] != 2'b11) begin
              next_st.wmode =
                pzd_wmode_t'(bus_req.wdata[`PZD_CFG_WMODE+1 -: 2]);
            end
            if (bus_req.wdata[`PZD_CFG_SPEED+1 -: 2] != 2'b11) begin
              next_st.speed =
                pzd_speed_t'(bus_req.wdata[`PZD_CFG_SPEED+1 -: 2]);
            end
          end
        end
        `PZD_OFS_STEP: if (st.hv_en) begin
          next_st.step = clamp($signed({2'b00, bus_req.wdata[15:0]}),
                               PZD_R150);
        end
        `PZD_OFS_SETPOINT: if (st.hv_en) begin
          next_st.drive = clamp($signed({2'b00, bus_req.wdata[15:0]}),
                                st.range);
        end
        `PZD_OFS_TEACH1: if (st.hv_en) begin
          next_st.teach1 = bus_req.wdata[15:0];
        end
        `PZD_OFS_TEACH2: if (st.hv_en) begin
          next_st.teach2 = bus_req.wdata[15:0];
        end
        default: ;
      endcase
    end

    // ---------------- runaway ramp without feedback ----------------
    ramp_lim = (st.range == PZD_R75) ? `PZD_VMAX_75 : `PZD_VMAX_150;
    next_st.ramping = st.hv_en && (st.loop == PZD_CLOSED) && !fb_present;
    if (st.ramping) begin
      if (st.ramp_cnt >= 16'(RAMP_CYCLES - 1)) begin
        next_st.ramp_cnt = 16'h0000;
        if (st.drive < ramp_lim) begin
          next_st.drive = st.drive + 16'h0001;
        end
      end else begin
        next_st.ramp_cnt = st.ramp_cnt + 16'h0001;
      end
    end else begin
      next_st.ramp_cnt = 16'h0000;
    end

    // ---------------- routing ----------------
    if (st.loop == PZD_CLOSED) begin
      next_st.route.route_en  = 1'b1;
      next_st.route.route_sel = (st.src == PZD_SRC_OFF) ? PZD_SRC_COAX
                                                        : st.src;
      next_st.route.drive_from_input    = 1'b0;
      next_st.route.feedback_from_input = 1'b1;
      next_st.route.modulation_accept   = 1'b0;
    end else begin
      next_st.route.route_en  = (st.src != PZD_SRC_OFF);
      next_st.route.route_sel = st.src;
      next_st.route.drive_from_input    = (st.src != PZD_SRC_OFF);
      next_st.route.feedback_from_input = 1'b0;
      next_st.route.modulation_accept   = 1'b1;
    end

    // ---------------- display ----------------
    unique case (st.src)
      PZD_SRC_COAX: next_st.disp.src_char = 8'h53;
      PZD_SRC_HUB1: next_st.disp.src_char = 8'h31;
      PZD_SRC_HUB2: next_st.disp.src_char = 8'h32;
      default:      next_st.disp.src_char = 8'h4E;
    endcase
    unique case (st.wmode)
      PZD_WM_ADJUST: next_st.disp.mode_char = 8'h41;
      PZD_WM_JOG:    next_st.disp.mode_char = 8'h4A;
      default:       next_st.disp.mode_char = 8'h47;
    endcase
    next_st.disp.show_percent = (st.loop == PZD_CLOSED);
    next_st.disp.menu = st.menu;
    next_st.disp.item = st.item;

    // ---------------- register reads ----------------
    next_st.rdata = 32'h0000_0000;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        `PZD_OFS_CONFIG:   next_st.rdata = {22'h00_0000, st.speed, st.wmode,
                                            st.src, st.loop, st.range,
                                            st.hv_en};
        `PZD_OFS_STEP:     next_st.rdata = {16'h0000, st.step};
        `PZD_OFS_SETPOINT: next_st.rdata = {16'h0000, st.drive};
        `PZD_OFS_TEACH1:   next_st.rdata = {16'h0000, st.teach1};
        `PZD_OFS_TEACH2:   next_st.rdata = {16'h0000, st.teach2};
        `PZD_OFS_STATUS:   next_st.rdata = {9'h000, st.item, st.menu,
                                            st.ramping, fb_present,
                                            st.drive};
        default:           next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st          <= '0;
      st.hv_en    <= 1'b0;
      st.loop     <= PZD_OPEN;
      st.range    <= PZD_R75;
      st.src      <= PZD_SRC_OFF;
      st.wmode    <= PZD_WM_ADJUST;
      st.speed    <= PZD_SP_HIGH;
      st.step     <= `PZD_STEP_RESET;
      st.teach1   <= `PZD_TEACH_RESET;
      st.teach2   <= `PZD_TEACH_RESET;
      st.menu     <= PZD_MS_MAIN;
      st.item     <= PZD_MI_HV;
      st.route.modulation_accept <= 1'b1;
      st.route.route_sel <= PZD_SRC_OFF;
      st.disp.src_char   <= 8'h4E;
      st.disp.mode_char  <= 8'h41;
    end else begin
      st <= next_st;
    end
  end

  assign bus_rdata                  = st.rdata;
  assign drive_code                 = st.drive;
  assign high_voltage_output_enable = st.hv_en;
  assign route                      = st.route;
  assign disp                       = st.disp;

endmodule : pzd_setpoint_ctrl

// >>> testbench/pzd_setpoint_ctrl_properties.sv
/*
 * port-level checker for the piezo setpoint control block.
 * assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
module pzd_setpoint_ctrl_chk
  import pzd_pkg::*;
#(
  parameter int RAMP_CYCLES = 4
) (
  input wire logic                   clk_sys,
  input wire logic                   rst_n,
  input wire logic                   wheel_up_pin,
  input wire logic                   wheel_down_pin,
  input wire logic                   menu_btn_pin,
  input wire logic                   feedback_present_pin,
  input wire pzd_pkg::pzd_bus_req_t  bus_req,
  input wire logic [31:0]            bus_rdata,
  input wire logic [15:0]            drive_code,
  input wire logic                   high_voltage_output_enable,
  input wire pzd_pkg::pzd_route_t    route,
  input wire pzd_pkg::pzd_disp_t     disp
);
  logic [7:0] exp_src;

  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  assign exp_src = route.route_sel == PZD_SRC_COAX ? 8'h53 :
                   route.route_sel == PZD_SRC_HUB1 ? 8'h31 :
                   route.route_sel == PZD_SRC_HUB2 ? 8'h32 : 8'h4E;

  sequence s_hv_off2;
    !high_voltage_output_enable [*2];
  endsequence
  sequence s_closed;
    route.feedback_from_input;
  endsequence

  AST_HV_LOCK: assert property (s_hv_off2 |-> $stable(drive_code))
    else $error("drive moved while output disabled");
  AST_NO_MOD: assert property (s_closed |-> !route.modulation_accept)
    else $error("modulation accepted in closed loop");
  AST_PERCENT: assert property (disp.show_percent ==
    route.feedback_from_input)
    else $error("percent display does not follow loop mode");
  AST_CLOSED_PATH: assert property (s_closed |-> route.route_en)
    else $error("input path off in closed loop");
  AST_FB_NOT_DRIVE: assert property (s_closed |-> !route.drive_from_input)
    else $error("input drives amplifier in closed loop");
  AST_OFF_PATH: assert property (!route.feedback_from_input &&
    route.route_sel == PZD_SRC_OFF |-> !route.route_en)
    else $error("input path enabled with source off");
  AST_OPEN_DRIVE: assert property (!route.feedback_from_input &&
    route.route_sel != PZD_SRC_OFF |-> route.drive_from_input)
    else $error("open loop input not driving amplifier");
  AST_SRC_CHAR: assert property (!route.feedback_from_input |->
    disp.src_char == exp_src)
    else $error("source character mismatch");
  AST_MODE_CHAR: assert property (disp.mode_char inside {8'h41, 8'h4A,
    8'h47})
    else $error("wheel mode character not A, J or G");
  AST_CLAMP: assert property (drive_code <= 16'h3A98)
    else $error("drive above the top limit");
  AST_COMMIT_MAIN: assert property ($rose(high_voltage_output_enable)
    |-> ##1 disp.menu == PZD_MS_MAIN)
    else $error("menu not back on main screen after commit");
endmodule : pzd_setpoint_ctrl_chk

// >>> testbench/pzd_user_model.sv
/*
 * model of the user at the wheel and button and of the position reader.
 * assumes pins are sampled through a synchroniser on clk_sys.
 */
`timescale 1ns/1ps
module pzd_user_model (
  input wire logic clk_sys,
  output logic     wheel_up_pin,
  output logic     wheel_down_pin,
  output logic     menu_btn_pin,
  output logic     feedback_present_pin
);
  initial begin
    wheel_up_pin = 1'b0;
    wheel_down_pin = 1'b0;
    menu_btn_pin = 1'b0;
    feedback_present_pin = 1'b0;
  end

  // ****************************************************************
  // one click: 0 up, 1 down, 2 menu; long enough to pass the filter
  // ****************************************************************
  task click(input int k);
    @(posedge clk_sys);
    wheel_up_pin <= (k == 0);
    wheel_down_pin <= (k == 1);
    menu_btn_pin <= (k == 2);
    repeat (6) @(posedge clk_sys);
    {wheel_up_pin, wheel_down_pin, menu_btn_pin} <= 3'h0;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask : click

  // reader feedback presence is driven on its own pin, apart from the routed channel
  task set_fb(input logic v);
    @(posedge clk_sys);
    feedback_present_pin <= v;
    repeat (8) @(posedge clk_sys);
    #1;
  endtask : set_fb
endmodule : pzd_user_model

// >>> testbench/tb_pzd_setpoint_ctrl.sv
/*
 * self-checking bench for the piezo setpoint control block.
 * assumes the user model drives pins and the bench owns the register port.
 */
`timescale 1ns/1ps
`include "pzd_params.svh"
module tb_pzd_setpoint_ctrl;
  import pzd_pkg::*;
  logic          clk_sys = 1'b0;
  logic          rst_n = 1'b0;
  pzd_bus_req_t  bus_req = '0;
  logic [31:0]   bus_rdata;
  logic [15:0]   drive_code;
  logic          hv;
  pzd_route_t    route;
  pzd_disp_t     disp;
  logic          wu, wd, mb, fb;
  logic [15:0]   vmax [3] = '{`PZD_VMAX_75, `PZD_VMAX_100, `PZD_VMAX_150};
  logic [7:0]    sc [4] = '{8'h53, 8'h31, 8'h32, 8'h4E};
  logic [7:0]    mc [3] = '{8'h41, 8'h4A, 8'h47};
  logic [15:0]   ad [3] = '{16'h0064, 16'h000A, 16'h0001};
  logic [15:0]   held;
  int            fails = 0;
  int            n_checks = 0;

  always #5 clk_sys = ~clk_sys;

  pzd_user_model m (
    .clk_sys(clk_sys),
    .wheel_up_pin(wu),
    .wheel_down_pin(wd),
    .menu_btn_pin(mb),
    .feedback_present_pin(fb)
  );

  pzd_setpoint_ctrl #(.RAMP_CYCLES(4)) uut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wheel_up_pin(wu),
    .wheel_down_pin(wd),
    .menu_btn_pin(mb),
    .feedback_present_pin(fb),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .drive_code(drive_code),
    .high_voltage_output_enable(hv),
    .route(route),
    .disp(disp)
  );

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge clk_sys);
    bus_req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1;
    chk(n, e, bus_rdata);
  endtask : rd

  function automatic logic [31:0] cfg(input logic h, input logic [1:0] r,
    input logic l, input logic [1:0] s, input logic [1:0] w,
    input logic [1:0] p);
    return {22'h00_0000, p, w, s, l, r, h};
  endfunction : cfg

  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("hv", 0, hv);
    chk("src_char", 8'h4E, disp.src_char);
    chk("mode_char", 8'h41, disp.mode_char);
    rd(8'h00, 32'h0000_0030, "config");
    wr(8'h08, 32'h0000_03E8);
    wr(8'h00, cfg(0, 2, 1, 0, 1, 1));
    rd(8'h00, 32'h0000_0030, "config_locked");
    chk("drive_locked", 0, drive_code);
    $display("test reset done");
    m.click(2);
    m.click(2);
    m.click(0);
    m.click(2);
    chk("hv_on", 1, hv);
    chk("menu_main", PZD_MS_MAIN, disp.menu);
    $display("test enable done");
    for (int r = 0; r < 3; r++) begin
      wr(8'h00, cfg(1, r, 0, 3, 0, 0));
      wr(8'h08, 32'h0000_FFFF);
      chk("drive_max", vmax[r], drive_code);
    end
    wr(8'h00, cfg(1, 0, 0, 3, 0, 0));
    chk("drive_shrunk", vmax[0], drive_code);
    for (int s = 0; s < 4; s++) begin
      wr(8'h00, cfg(1, 0, 0, s, 0, 0));
      chk("src_char", sc[s], disp.src_char);
      chk("route_en", s != 3, route.route_en);
    end
    for (int w = 0; w < 3; w++) begin
      wr(8'h00, cfg(1, 0, 0, 0, w, 0));
      chk("mode_char", mc[w], disp.mode_char);
    end
    $display("test settings done");
    for (int p = 0; p < 3; p++) begin
      wr(8'h00, cfg(1, 0, 0, 0, 0, p));
      wr(8'h08, 32'h0000_1388);
      m.click(0);
      chk("adjust", 16'h1388 + ad[p], drive_code);
    end
    wr(8'h00, cfg(1, 0, 0, 0, 1, 0));
    wr(8'h04, 32'h0000_0025);
    wr(8'h08, 32'h0000_1388);
    m.click(0);
    chk("jog_up", 16'h13AD, drive_code);
    m.click(1);
    chk("jog_down", 16'h1388, drive_code);
    m.click(2);
    repeat (5) m.click(0);
    m.click(2);
    m.click(0);
    m.click(2);
    rd(8'h04, 32'h0000_0026, "step");
    chk("item", PZD_MI_WPARAM, disp.item);
    chk("menu_main", PZD_MS_MAIN, disp.menu);
    wr(8'h0C, 32'h0000_04D2);
    wr(8'h10, 32'h0000_10E1);
    wr(8'h00, cfg(1, 0, 0, 0, 2, 0));
    m.click(0);
    chk("preset_up", 16'h10E1, drive_code);
    m.click(1);
    chk("preset_down", 16'h04D2, drive_code);
    $display("test wheel done");
    wr(8'h00, cfg(1, 1, 0, 3, 0, 0));
    wr(8'h08, 32'h0000_2700);
    wr(8'h00, cfg(1, 1, 1, 3, 0, 0));
    chk("fb_path", 1, route.feedback_from_input);
    chk("route_en", 1, route.route_en);
    chk("mod_ok", 0, route.modulation_accept);
    chk("percent", 1, disp.show_percent);
    m.set_fb(1'b1);
    held = drive_code;
    repeat (30) @(posedge clk_sys);
    #1;
    chk("ramp_held", held, drive_code);
    m.set_fb(1'b0);
    for (int i = 0; i < 40000 && drive_code !== 16'h3A98; i++)
      @(posedge clk_sys);
    #1;
    chk("ramp_top", 16'h3A98, drive_code);
    repeat (30) @(posedge clk_sys);
    #1;
    chk("ramp_stop", 16'h3A98, drive_code);
    rd(8'h14, 32'h0052_3A98, "status");
    $display("test closed loop done");
    give_verdict();
  end
endmodule : tb_pzd_setpoint_ctrl

bind pzd_setpoint_ctrl pzd_setpoint_ctrl_chk #(.RAMP_CYCLES(RAMP_CYCLES))
  u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .wheel_up_pin(wheel_up_pin),
  .wheel_down_pin(wheel_down_pin), .menu_btn_pin(menu_btn_pin),
  .feedback_present_pin(feedback_present_pin), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .drive_code(drive_code),
  .high_voltage_output_enable(high_voltage_output_enable),
  .route(route), .disp(disp));
